// [logic/halt_standby_wake_control.sv]
// Halt controller: standby levels, wake sources, warm-up and pin drive gating.
// Assumes wake pins are synchronous to mclk and a single Avalon-MM master.
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// Operation
// RQ1: Primary interrupt pin releases clock-gated idle
// RQ2: Partial idle runs only selected peripherals
// RQ3: Clock-gated idle stops system clock, oscillator runs
// RQ4: Wake sampled unclocked, restart aligned to clock
// RQ5: Deep idle keeps only slow oscillator, RTC
// RQ6: Full stop halts every circuit and oscillator
// RQ7: Drive-enable bit selects standby pin drive
// RQ8: Warm-up then settling before clock restarts
// RQ9: Deep idle/stop released by NMI, INT, wake
// RQ10: Warm-up counter runs even with external oscillator
// RQ11: Reset release must cover oscillator settling
// RQ12: Stop exit reinitializes RTC frequency register
// RQ13: Interrupt service waits for both intervals
// RQ14: Outputs float unless drive-enable bit set
// RQ15: General inputs disabled, control inputs stay live
// RQ16: Live inputs held steady by outside circuit
// RQ17: Primary interrupt resumes even when masked
// RQ18: Interrupt release keeps settings, reset reinitializes
// RQ19: Halt enters programmed level until release
module halt_standby_wake_control
  import halt_pkg::*;
#(
  parameter int WARMUP = halt_pkg::WARMUP_CYCLES,
  parameter int SETTLE = halt_pkg::SETTLE_CYCLES,
  parameter int NPORT = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [halt_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Wake sources
  input wire logic nmi_pin,
  input wire logic primary_ext_irq_pin,
  input wire logic [7:0] wake_pins,
  input wire logic irq_enabled,
  // Clock and oscillator control
  output logic sys_clk_en,
  output logic main_osc_en,
  output logic doubler_en,
  output logic [7:0] periph_clk_en,
  output logic cpu_run,
  output logic irq_service,
  // General port gating
  input wire logic [NPORT-1:0] port_out_val,
  input wire logic [NPORT-1:0] port_dir_out,
  input wire logic [NPORT-1:0] port_in_pad,
  output logic [NPORT-1:0] port_out,
  output logic [NPORT-1:0] port_oe,
  output logic [NPORT-1:0] port_in,
  // Interrupt
  output logic irq
);
  import halt_pkg::*;

  // Elaboration check: both intervals must fit the shared counter
  if (WARMUP < 1 || SETTLE < 1 || WARMUP >= (1 << CNT_W) || SETTLE >= (1 << CNT_W))
  begin : g_interval_range
    $error("interval out of counter range");
  end

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_HALT = 3'b001,
    ST_WARM = 3'b011,
    ST_SETTLE = 3'b010,
    ST_RESUME = 3'b110
  } state_e;

  state_e state_r, state_nxt;
  logic [1:0] mode_r, mode_nxt;
  logic [7:0] idle_periph_r, idle_periph_nxt;
  logic drive_en_r, drive_en_nxt;
  logic [7:0] rtc_freq_r, rtc_freq_nxt;
  logic [EV_W-1:0] irq_stat_r, irq_stat_nxt;
  logic [EV_W-1:0] irq_mask_r, irq_mask_nxt;
  logic nmi_wake_r, nmi_wake_nxt;
  logic service_r, service_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdata_nxt;
  logic timer_start;
  logic [CNT_W-1:0] timer_len;
  logic timer_done;
  logic wake_any, deep_wake, halt_cmd, deep_mode;
  logic [EV_W-1:0] events;

  // Shared interval counter for warm-up and doubler settling
  interval_timer #(.WIDTH(CNT_W)) u_timer (
    .mclk(mclk),
    .rst(rst),
    .start(timer_start),
    .length(timer_len),
    .busy(),
    .done(timer_done)
  );

  // Wake qualification per level; pins are level inputs so no clock edge is needed
  always_comb
  begin
    deep_mode = (mode_r == MODE_DEEP) || (mode_r == MODE_STOP);
    deep_wake = nmi_pin | primary_ext_irq_pin | (|wake_pins); // [RQ9] [RQ4]
    case (mode_r)
      MODE_CLOCK_GATED: wake_any = nmi_pin | primary_ext_irq_pin; // [RQ1]
      MODE_PARTIAL_IO: wake_any = nmi_pin | primary_ext_irq_pin | (|wake_pins);
      default: wake_any = deep_wake;
    endcase
    halt_cmd = avs_write && !avs_waitrequest && (avs_address == {1'b0, ADDR_CTRL})
      && avs_writedata[CTRL_HALT_BIT];
  end

  // Halt sequencer
  always_comb
  begin
    state_nxt = state_r;
    timer_start = 1'b0;
    timer_len = CNT_W'(WARMUP);
    nmi_wake_nxt = nmi_wake_r;
    service_nxt = 1'b0;
    case (state_r)
      ST_RUN:
        if (halt_cmd)
          state_nxt = ST_HALT; // [RQ19]
      ST_HALT:
        if (wake_any)
        begin
          nmi_wake_nxt = nmi_pin;
          if (deep_mode)
          begin
            timer_start = 1'b1; // [RQ8] [RQ10]
            state_nxt = ST_WARM;
          end
          else
            state_nxt = ST_RESUME; // [RQ4]
        end
      ST_WARM:
        if (timer_done)
        begin
          timer_start = 1'b1;
          timer_len = CNT_W'(SETTLE);
          state_nxt = ST_SETTLE;
        end
      ST_SETTLE:
        if (timer_done)
          state_nxt = ST_RESUME; // [RQ13]
      ST_RESUME:
      begin
        // Masked primary interrupt still resumes, just without service
        service_nxt = nmi_wake_r | irq_enabled; // [RQ17]
        state_nxt = ST_RUN;
      end
      default: state_nxt = ST_RUN;
    endcase
  end

  // Register writes, sticky events, RTC reinit on stop exit
  always_comb
  begin
    mode_nxt = mode_r;
    idle_periph_nxt = idle_periph_r;
    drive_en_nxt = drive_en_r;
    rtc_freq_nxt = rtc_freq_r;
    irq_mask_nxt = irq_mask_r;
    rdata_nxt = 32'h0;
    ack_nxt = 1'b0;
    events = '0;
    events[EV_WAKE] = (state_r == ST_HALT) && wake_any;
    events[EV_NMI] = (state_r == ST_HALT) && wake_any && nmi_pin;
    events[EV_CLOCK_UP] = (state_r == ST_RESUME);
    events[EV_STOP_EXIT] = (state_r == ST_RESUME) && (mode_r == MODE_STOP);
    irq_stat_nxt = irq_stat_r;
    if ((avs_read || avs_write) && !ack_r)
    begin
      ack_nxt = 1'b1;
      case (avs_address)
        {1'b0, ADDR_CTRL}: rdata_nxt = {26'h0, mode_r, 4'h0};
        {1'b0, ADDR_IDLE_PERIPH}: rdata_nxt = {24'h0, idle_periph_r};
        {1'b0, ADDR_WATCHDOG_MODE}: rdata_nxt = {24'h0, drive_en_r, 7'h0};
        {1'b0, ADDR_STATUS}: rdata_nxt = {29'h0, state_r};
        ADDR_IRQ_STATUS_FULL: rdata_nxt = {28'h0, irq_stat_r};
        ADDR_IRQ_MASK_FULL: rdata_nxt = {28'h0, irq_mask_r};
        ADDR_RTC_FREQ_FULL: rdata_nxt = {24'h0, rtc_freq_r};
        default: rdata_nxt = 32'h0;
      endcase
      if (avs_read && avs_address == ADDR_IRQ_STATUS_FULL)
        irq_stat_nxt = '0;
    end
    // Writes land only at the edge where the master sees waitrequest low
    if (avs_write && !avs_waitrequest)
      case (avs_address)
        {1'b0, ADDR_CTRL}: mode_nxt = avs_writedata[CTRL_MODE_LSB +: 2];
        {1'b0, ADDR_IDLE_PERIPH}: idle_periph_nxt = avs_writedata[7:0];
        {1'b0, ADDR_WATCHDOG_MODE}: drive_en_nxt = avs_writedata[WDMODE_DRIVE_BIT]; // [RQ7]
        ADDR_IRQ_MASK_FULL: irq_mask_nxt = avs_writedata[EV_W-1:0];
        ADDR_RTC_FREQ_FULL: rtc_freq_nxt = avs_writedata[7:0];
        default: ;
      endcase
    // Set wins over the read clear
    irq_stat_nxt = irq_stat_nxt | events;
    // Release from full stop loses the RTC frequency setting
    if (events[EV_STOP_EXIT])
      rtc_freq_nxt = RTC_FREQ_RST; // [RQ12]
  end

  // Sync reset restores settings; RAM is outside this block and untouched [RQ18]
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_r <= ST_RUN;
      mode_r <= MODE_RST;
      idle_periph_r <= IDLE_PERIPH_RST;
      drive_en_r <= WDMODE_DRIVE_RST;
      rtc_freq_r <= RTC_FREQ_RST;
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      nmi_wake_r <= 1'b0;
      service_r <= 1'b0;
      ack_r <= 1'b0;
      avs_readdata <= 32'h0;
    end
    else
    begin
      state_r <= state_nxt;
      mode_r <= mode_nxt;
      idle_periph_r <= idle_periph_nxt;
      drive_en_r <= drive_en_nxt;
      rtc_freq_r <= rtc_freq_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      nmi_wake_r <= nmi_wake_nxt;
      service_r <= service_nxt;
      ack_r <= ack_nxt;
      avs_readdata <= rdata_nxt;
    end
  end

  // Registered outputs derived from next state so they match state_r
  logic halted_nxt, deep_nxt;
  always_comb
  begin
    halted_nxt = (state_nxt != ST_RUN) && (state_nxt != ST_RESUME);
    deep_nxt = halted_nxt && ((mode_nxt == MODE_DEEP) || (mode_nxt == MODE_STOP)
      || (state_nxt == ST_WARM) || (state_nxt == ST_SETTLE));
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sys_clk_en <= 1'b1;
      main_osc_en <= 1'b1;
      doubler_en <= 1'b1;
      periph_clk_en <= 8'hff;
      cpu_run <= 1'b1;
      irq_service <= 1'b0;
      port_out <= '0;
      port_oe <= '0;
      port_in <= '0;
      irq <= 1'b0;
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      sys_clk_en <= !halted_nxt || (mode_nxt == MODE_PARTIAL_IO && state_nxt == ST_HALT); // [RQ3]
      main_osc_en <= !deep_nxt || state_nxt == ST_WARM || state_nxt == ST_SETTLE; // [RQ5] [RQ6]
      doubler_en <= !deep_nxt || state_nxt == ST_SETTLE;
      periph_clk_en <= !halted_nxt ? 8'hff
        : (mode_nxt == MODE_PARTIAL_IO && state_nxt == ST_HALT) ? idle_periph_nxt : 8'h00; // [RQ2]
      cpu_run <= !halted_nxt;
      irq_service <= service_nxt;
      port_out <= port_out_val;
      port_oe <= (deep_nxt && !drive_en_nxt) ? '0 : port_dir_out; // [RQ14]
      port_in <= deep_nxt ? '0 : port_in_pad; // [RQ15]
      irq <= |(irq_stat_nxt & irq_mask_nxt);
      avs_waitrequest <= !((avs_read || avs_write) && !ack_r);
    end
  end

  // Checks
  a_clock_gated_off: assert property (@(posedge mclk) disable iff (rst)
    (state_r == ST_HALT && mode_r == MODE_CLOCK_GATED) |-> !sys_clk_en && main_osc_en) // [RQ3]
    else $error("clock-gated idle clock state wrong");
  a_warm_then_settle: assert property (@(posedge mclk) disable iff (rst)
    (state_r == ST_HALT && deep_mode && wake_any) |=> state_r == ST_WARM) // [RQ8]
    else $error("deep wake skipped warm-up");
  a_settle_resume: assert property (@(posedge mclk) disable iff (rst)
    (state_r == ST_SETTLE && timer_done) |=> state_r == ST_RESUME ##1 cpu_run) // [RQ13]
    else $error("resume not after settling");
  a_clock_held_warm: assert property (@(posedge mclk) disable iff (rst)
    (state_r == ST_WARM || state_r == ST_SETTLE) |-> !cpu_run) // [RQ10]
    else $error("cpu ran during warm-up");
  a_float_ports: assert property (@(posedge mclk) disable iff (rst)
    (state_r == ST_HALT && deep_mode && !drive_en_r) |-> port_oe == '0) // [RQ14]
    else $error("port driven in deep standby");
  a_inputs_off: assert property (@(posedge mclk) disable iff (rst)
    (state_r == ST_HALT && deep_mode) |-> port_in == '0) // [RQ15]
    else $error("inputs live in deep standby");
  a_rtc_reinit: assert property (@(posedge mclk) disable iff (rst)
    events[EV_STOP_EXIT] |=> rtc_freq_r == RTC_FREQ_RST) // [RQ12]
    else $error("rtc frequency not reinitialized");
  a_periph_select: assert property (@(posedge mclk) disable iff (rst)
    (state_r == ST_HALT && mode_r == MODE_PARTIAL_IO) |-> periph_clk_en == idle_periph_r) // [RQ2]
    else $error("partial idle peripheral clocks wrong");
  a_halt_stays: assert property (@(posedge mclk) disable iff (rst)
    (state_r == ST_HALT && !wake_any) |=> state_r == ST_HALT) // [RQ19]
    else $error("halt left without release");
  c_stop_wake: cover property (@(posedge mclk) disable iff (rst)
    state_r == ST_SETTLE && mode_r == MODE_STOP ##1 state_r == ST_RESUME);
  c_gated_wake: cover property (@(posedge mclk) disable iff (rst)
    state_r == ST_HALT && mode_r == MODE_CLOCK_GATED ##1 state_r == ST_RESUME);
  c_partial_wake: cover property (@(posedge mclk) disable iff (rst)
    state_r == ST_HALT && mode_r == MODE_PARTIAL_IO ##1 state_r == ST_RESUME);
endmodule
`default_nettype wire

// [logic/halt_pkg.sv]
// Constants for the halt, standby and wake controller.
// Assumes a 200 MHz mclk and an Avalon-MM register slave with 32-bit data.
package halt_pkg;
  // Standby level codes held in the mode field
  localparam logic [1:0] MODE_PARTIAL_IO = 2'h0;
  localparam logic [1:0] MODE_CLOCK_GATED = 2'h1;
  localparam logic [1:0] MODE_DEEP = 2'h2;
  localparam logic [1:0] MODE_STOP = 2'h3;
  // Register byte addresses
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_IDLE_PERIPH = 4'h4;
  localparam logic [3:0] ADDR_WATCHDOG_MODE = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hc;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h0;
  // Byte address bits decoded; the top address bit selects the second bank
  localparam int ADDR_W = 5;
  localparam logic [4:0] ADDR_IRQ_STATUS_FULL = 5'h10;
  localparam logic [4:0] ADDR_IRQ_MASK_FULL = 5'h14;
  localparam logic [4:0] ADDR_RTC_FREQ_FULL = 5'h18;
  // Field positions
  localparam int CTRL_HALT_BIT = 0;
  localparam int CTRL_MODE_LSB = 4;
  localparam int WDMODE_DRIVE_BIT = 7;
  // Reset values
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [7:0] IDLE_PERIPH_RST = 8'h00;
  localparam logic [7:0] RTC_FREQ_RST = 8'h00;
  localparam logic WDMODE_DRIVE_RST = 1'b0;
  // Interrupt status bit positions
  localparam int EV_WAKE = 0;
  localparam int EV_NMI = 1;
  localparam int EV_CLOCK_UP = 2;
  localparam int EV_STOP_EXIT = 3;
  localparam int EV_W = 4;
  // Warm-up and doubler settling: 320000 mclk cycles each, 1.6 ms
  localparam real MCLK_MHZ = 200.0;
  localparam real WARMUP_MS = 1.6;
  localparam int WARMUP_CYCLES = int'(WARMUP_MS * 1000.0 * MCLK_MHZ);
  localparam int SETTLE_CYCLES = int'(WARMUP_MS * 1000.0 * MCLK_MHZ);
  localparam int CNT_W = 20;
endpackage

// [logic/interval_timer.sv]
// One-shot down counter used for warm-up and doubler settling intervals.
// Assumes a single mclk domain; load and count are synchronous.
`timescale 1ns/100ps
`default_nettype none
module interval_timer #(
  parameter int WIDTH = 20
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Control
  input wire logic start,
  input wire logic [WIDTH-1:0] length,
  // Result
  output logic busy,
  output logic done
);
  logic [WIDTH-1:0] cnt_r;
  logic [WIDTH-1:0] cnt_nxt;
  logic done_nxt;

  // Load on start, count down to zero, pulse done on the step from one
  always_comb
  begin
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    if (start)
      cnt_nxt = length;
    else if (cnt_r != '0)
    begin
      cnt_nxt = cnt_r - 1'b1;
      done_nxt = (cnt_r == {{(WIDTH-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cnt_r <= '0;
      done <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      done <= done_nxt;
    end
  end

  assign busy = (cnt_r != '0);
endmodule
`default_nettype wire

// [sim/wake_src_model.sv]
// Far-side model of the wake, primary interrupt and non-maskable pins.
// Assumes the bench requests a level and holds it until the halt ends.
`timescale 1ns/100ps
`default_nettype none
module wake_src_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Bench request
  input wire logic hold,
  input wire logic [1:0] sel,
  input wire logic [2:0] pin_idx,
  // Pins toward the block
  output logic nmi_pin,
  output logic primary_ext_irq_pin,
  output logic [7:0] wake_pins
);
  // Live inputs sit at a fixed low level unless held, so they never wander
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      nmi_pin <= 1'b0;
      primary_ext_irq_pin <= 1'b0;
      wake_pins <= 8'h00;
    end
    else
    begin
      nmi_pin <= hold && sel == 2'h0;
      primary_ext_irq_pin <= hold && sel == 2'h1;
      wake_pins <= (hold && sel == 2'h2) ? 8'h01 << pin_idx : 8'h00;
    end
  end
endmodule
`default_nettype wire

// [sim/halt_standby_wake_control_tb_top.sv]
// Self-checking bench for the halt controller: bus tasks and standby scenarios.
// Assumes the wake source model and shortened warm-up and settling counts.
`timescale 1ns/100ps
`default_nettype none
module halt_standby_wake_control_tb_top;
  import halt_pkg::*;
  localparam int WU = 8;
  localparam int ST = 8;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rdata_s, rd;
  logic avs_waitrequest, wait_s, nmi_pin, primary_ext_irq_pin, irq;
  logic [7:0] wake_pins, periph_clk_en, port_out, port_oe, port_in;
  logic irq_enabled = 1'b1;
  logic sys_clk_en, main_osc_en, doubler_en, cpu_run, irq_service;
  logic [7:0] port_out_val = 8'h5a;
  logic [7:0] port_dir_out = 8'h0f;
  logic [7:0] port_in_pad = 8'hc3;
  logic hold = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [2:0] pin_idx = 3'h0;
  int svc_cnt = 0;
  int svc_base = 0;
  int n_fail = 0;
  int checks = 0;
  int cnt;

  always #2.5 mclk = ~mclk;

  halt_standby_wake_control #(.WARMUP(WU), .SETTLE(ST), .NPORT(8)) halt_standby_wake_control_inst (
    .mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .nmi_pin(nmi_pin),
    .primary_ext_irq_pin(primary_ext_irq_pin), .wake_pins(wake_pins),
    .irq_enabled(irq_enabled), .sys_clk_en(sys_clk_en), .main_osc_en(main_osc_en),
    .doubler_en(doubler_en), .periph_clk_en(periph_clk_en), .cpu_run(cpu_run),
    .irq_service(irq_service), .port_out_val(port_out_val), .port_dir_out(port_dir_out),
    .port_in_pad(port_in_pad), .port_out(port_out), .port_oe(port_oe), .port_in(port_in),
    .irq(irq));

  wake_src_model wake_src_model_inst (.mclk(mclk), .rst(rst), .hold(hold), .sel(sel),
    .pin_idx(pin_idx), .nmi_pin(nmi_pin), .primary_ext_irq_pin(primary_ext_irq_pin),
    .wake_pins(wake_pins));

  // Registered outputs are captured mid-cycle, so the next edge sees them settled
  always @(negedge mclk)
  begin
    wait_s <= avs_waitrequest;
    rdata_s <= avs_readdata;
    if (irq_service === 1'b1)
      svc_cnt <= svc_cnt + 1;
  end

  task automatic tally_and_finish;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One bus transfer held until waitrequest is seen low at an edge
  task automatic bus(input logic wr_en, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int i;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr_en;
    avs_read <= !wr_en;
    for (i = 0; i < 50; i++)
    begin
      @(posedge mclk);
      if (wait_s === 1'b0)
        break;
    end
    if (i == 50)
    begin
      n_fail++;
      tally_and_finish();
    end
    q = rdata_s;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, rd);
    chk(rd, e);
  endtask

  task automatic halt(input logic [1:0] m);
    wr({1'b0, ADDR_CTRL}, (32'(m) << CTRL_MODE_LSB) | (32'h1 << CTRL_HALT_BIT));
    repeat (3) @(negedge mclk);
  endtask

  task automatic wake(input logic [1:0] s, input logic [2:0] idx, input logic en);
    @(posedge mclk);
    sel <= s;
    pin_idx <= idx;
    hold <= 1'b1;
    irq_enabled <= en;
    svc_base = svc_cnt;
  endtask

  // Bounded wait for the processor to run again, then the pin is let go
  task automatic wait_run(output int c);
    c = 0;
    while (cpu_run !== 1'b1)
    begin
      @(negedge mclk);
      c++;
      if (c > 100)
      begin
        n_fail++;
        tally_and_finish();
      end
    end
    @(posedge mclk);
    hold <= 1'b0;
    // One more edge so the service pulse at resume has been captured
    @(posedge mclk);
  endtask

  // Main sequence
  initial
  begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    chk({sys_clk_en, main_osc_en, doubler_en, cpu_run, irq}, 5'h1e);
    rdc({1'b0, ADDR_WATCHDOG_MODE}, 32'h0);
    chk(port_in, port_in_pad);
    wr(5'h1c, 32'hffffffff);
    rdc(5'h1c, 32'h0);
    // Partial idle: only the selected peripherals keep their clocks
    wr({1'b0, ADDR_IDLE_PERIPH}, 32'ha5);
    halt(MODE_PARTIAL_IO);
    chk({cpu_run, periph_clk_en}, 9'h0a5);
    rdc({1'b0, ADDR_STATUS}, 32'h1);
    wake(2'h2, 3'h3, 1'b1);
    wait_run(cnt);
    chk(cnt <= 4, 1'b1);
    // Clock-gated idle, primary pin releases it even when the level is masked
    wr(ADDR_IRQ_MASK_FULL, 32'hf);
    bus(1'b0, ADDR_IRQ_STATUS_FULL, 32'h0, rd);
    halt(MODE_CLOCK_GATED);
    chk({sys_clk_en, main_osc_en, cpu_run}, 3'h2);
    wake(2'h1, 3'h0, 1'b0);
    wait_run(cnt);
    chk(cnt <= 4, 1'b1);
    chk(svc_cnt - svc_base, 32'h0);
    chk(irq, 1'b1);
    bus(1'b0, ADDR_IRQ_STATUS_FULL, 32'h0, rd);
    chk(rd[EV_WAKE], 1'b1);
    repeat (2) @(negedge mclk);
    chk(irq, 1'b0);
    // Deep idle, outputs float with drive disabled, released by the NMI pin
    halt(MODE_DEEP);
    chk({sys_clk_en, main_osc_en, cpu_run}, 3'h0);
    chk({port_oe, port_in}, 16'h0000);
    wake(2'h0, 3'h0, 1'b1);
    repeat (WU) @(negedge mclk);
    chk({main_osc_en, sys_clk_en}, 2'h2);
    wait_run(cnt);
    chk(cnt + WU >= WU + ST, 1'b1);
    chk({(svc_cnt - svc_base) == 1, sys_clk_en}, 2'h3);
    // Full stop with drive enabled, released by the last wake pin
    wr(ADDR_RTC_FREQ_FULL, 32'h3c);
    wr({1'b0, ADDR_WATCHDOG_MODE}, 32'h80);
    bus(1'b0, ADDR_IRQ_STATUS_FULL, 32'h0, rd);
    halt(MODE_STOP);
    chk({main_osc_en, doubler_en, sys_clk_en}, 3'h0);
    chk(port_oe, port_dir_out);
    chk(port_out & port_dir_out, port_out_val & port_dir_out);
    wake(2'h2, 3'h7, 1'b1);
    wait_run(cnt);
    chk(cnt >= WU + ST, 1'b1);
    rdc(ADDR_RTC_FREQ_FULL, 32'h0);
    rdc({1'b0, ADDR_IDLE_PERIPH}, 32'ha5);
    rdc({1'b0, ADDR_WATCHDOG_MODE}, 32'h80);
    wr(ADDR_RTC_FREQ_FULL, 32'h3c);
    rdc(ADDR_RTC_FREQ_FULL, 32'h3c);
    bus(1'b0, ADDR_IRQ_STATUS_FULL, 32'h0, rd);
    chk(rd & 32'h9, 32'h9);
    // Stop released by a reset held over warm-up and settling
    halt(MODE_STOP);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (WU + ST) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    chk({sys_clk_en, main_osc_en, doubler_en, cpu_run}, 4'hf);
    rdc({1'b0, ADDR_STATUS}, 32'h0);
    rdc({1'b0, ADDR_IDLE_PERIPH}, 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
